// file: pkg/cwt_pkg.sv
// Constants and carrier types for the codeword transceiver
package cwt_pkg;

  // ------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CFG = 8'ha0;
  localparam logic [7:0] IDX_TXCW = 8'ha1;
  localparam logic [7:0] IDX_RXCW = 8'ha2;
  localparam logic [7:0] IDX_STAT = 8'ha3;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_RXEN_BIT = 7;
  localparam int CFG_INTEG_BIT = 6;
  localparam int CFG_RXLEN_LSB = 4;
  localparam int CFG_TXLEN_LSB = 2;
  localparam int CFG_MODE_LSB = 0;
  localparam int RX_LOST_BIT = 7;
  localparam int RX_NEW_BIT = 6;
  localparam int STAT_TXACT_BIT = 7;
  localparam int STAT_RXACT_BIT = 6;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [5:0] CW_RST = 6'h00;

  // ------------------------------------------------------------
  // Length codes, counts and priority modes
  // ------------------------------------------------------------
  localparam logic [1:0] LEN_ONE = 2'b00;
  localparam logic [1:0] LEN_TEN = 2'b01;
  localparam logic [1:0] LEN_25 = 2'b10;
  localparam logic [1:0] LEN_CONT = 2'b11;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_TEN = 5'h0a;
  localparam logic [4:0] CNT_25 = 5'h19;
  localparam logic [1:0] MODE_CWPRI = 2'b10;
  localparam logic [1:0] MODE_L1PRI = 2'b11;

  // ------------------------------------------------------------
  // Pattern timing in data link bit times
  // ------------------------------------------------------------
  localparam logic [4:0] PAT_BITS = 5'h10;
  localparam logic [3:0] PAT_LAST = 4'hf;
  localparam logic [7:0] FLAG_ONES = 8'hff;
  localparam int ABORT_BITS = 8;

  // Link-side inputs from the framer, same clock
  typedef struct packed {
    logic bitEn;
    logic rxBit;
    logic l1Empty;
    logic l1Idle;
  } cwt_link_in_t;

  // Link-side outputs toward the framer
  typedef struct packed {
    logic txBit;
    logic cwOwns;
    logic l1Suspend;
  } cwt_link_out_t;

  // Event pulses toward the interrupt status registers
  typedef struct packed {
    logic rxCwEvt;
    logic txCwEvt;
  } cwt_evt_t;

endpackage

// file: hdl/cwt_transceiver.sv
// Codeword transceiver: APB registers, pattern receiver, sender
//
// Overview of operation
// RL1 - Receiver scans channel only while enabled
// RL2 - Integration needs two clean back-to-back patterns
// RL3 - Integration adds one pattern to qualification
// RL4 - Software enables integration for noisy lines
// RL5 - Receive length picks 1, 10, 25, change
// RL6 - Qualify loads codeword and raises receive event
// RL7 - Gaps allowed unless different codeword intervenes
// RL8 - Transmit write sends 1, 10, 25, continuous
// RL9 - Transmit event at start; next write allowed
// RL10 - No pending write: channel returns to link1
// RL11 - Software ends continuous by changing length
// RL12 - Priority field: off, codeword, link1 first
// RL13 - Codeword priority aborts link1 within eight bits
// RL14 - Link1 buffer writes still accepted meanwhile
// RL15 - Link1 priority pauses codeword until idle
// RL16 - Continuous codeword yields at pattern boundary
// RL17 - Transmit codeword sent bit 0 first
// RL18 - Received codeword stored in arrival order
// RL19 - New flag sets on update, clears on read
// RL20 - Update while new set raises overwrite
// RL21 - Transmit busy bit spans whole message
// RL22 - Receive busy sets on pattern detection
// RL23 - Receive busy pulse or held until qualify
// RL24 - Pattern: eight ones, zero, codeword, zero
// RL25 - Uses channel chosen by link1 select
// RL26 - Disabled receiver leaves results unchanged
`timescale 1ns/1ps

module cwt_transceiver
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data link channel
  input wire cwt_pkg::cwt_link_in_t linkIn,
  output cwt_pkg::cwt_link_out_t linkOut,
  // Event pulses
  output cwt_pkg::cwt_evt_t evt
);
  import cwt_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_HOLD} cwt_tx_state_t;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic accDone;
  logic [7:0] cfg;
  logic [5:0] txCwReg;
  logic [5:0] rxCw;
  logic rxNew;
  logic rxLost;
  logic rxActive;
  cwt_tx_state_t txState;

  // Address decode on word index, upper bits must be zero
  wire apbAcc = psel & penable;
  wire [7:0] wordIdx = paddr[9:2];
  wire upperZero = (paddr[ADDR_W-1:10] == '0);
  wire selCfg = upperZero & (wordIdx == IDX_CFG);
  wire selTx = upperZero & (wordIdx == IDX_TXCW);
  wire selRx = upperZero & (wordIdx == IDX_RXCW);
  wire selStat = upperZero & (wordIdx == IDX_STAT);
  wire anySel = selCfg | selTx | selRx | selStat;
  wire fire = apbAcc & accDone;
  wire wrFire = fire & pwrite;
  wire rdRx = fire & ~pwrite & selRx;

  // One wait state so read data comes from a flip-flop
  assign pready = fire;
  assign pslverr = fire & ~anySel;

  // Busy status covers pauses too, so it spans the message
  wire txBusy = (txState != TX_IDLE); // [RL21]

  // Read mux, unused bits read zero
  wire [7:0] rdByte =
    selCfg ? cfg :
    selTx ? {2'b00, txCwReg} :
    selRx ? {rxLost, rxNew, rxCw} :
    selStat ? {txBusy, rxActive, 6'h00} : // [RL21] [RL22]
    8'h00;

  // Access phase tracking and read capture
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      accDone <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      accDone <= apbAcc & ~accDone;
      if (apbAcc & ~accDone)
        prdata <= {24'h00_0000, rdByte};
    end
  end

  // ------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------
  wire rxEn = cfg[CFG_RXEN_BIT];
  wire integ = cfg[CFG_INTEG_BIT];
  wire [1:0] rxLen = cfg[CFG_RXLEN_LSB +: 2];
  wire [1:0] txLen = cfg[CFG_TXLEN_LSB +: 2];
  wire [1:0] mode = cfg[CFG_MODE_LSB +: 2];
  wire txOn = mode[1]; // [RL12]
  wire l1Pri = (mode == MODE_L1PRI); // [RL12]

  // Configuration register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      cfg <= CFG_RST;
    else if (wrFire & selCfg)
      cfg <= pwdata[7:0];
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic [15:0] rxShift;
  logic rxChk;
  logic [4:0] bitsSince;
  logic [5:0] prevCw;
  logic [5:0] runCw;
  logic [4:0] runCnt;

  // The bit strobe already marks the slots that the link1
  // channel select picks, so this block needs no slot logic
  wire rxStep = linkIn.bitEn & rxEn; // [RL25] [RL1]

  // Pattern check looks at the window after each new bit
  // Gated by the enable so a pattern ending in the slot that
  // turned the receiver off cannot still qualify
  wire patHit = rxChk & rxEn & (rxShift[7:0] == FLAG_ONES)
    & ~rxShift[8] & ~rxShift[15]; // [RL1] [RL26]
  wire [5:0] hitCw = rxShift[14:9]; // [RL18]

  // Integration: same codeword exactly one pattern ago
  wire backToBack = (bitsSince == PAT_BITS)
    & (hitCw == prevCw);
  wire intHit = patHit & (~integ | backToBack); // [RL2] [RL3]

  // Target count for the selected receive length
  wire [4:0] target =
    (rxLen == LEN_TEN) ? CNT_TEN :
    (rxLen == LEN_25) ? CNT_25 : CNT_ONE; // [RL5]

  // A different codeword starts a new run
  wire cwChanged = (hitCw != runCw) | (runCnt == 5'h00); // [RL7]
  wire atTarget = (runCnt == target);
  wire [4:0] cntNext = cwChanged ? CNT_ONE :
    atTarget ? runCnt : runCnt + 5'h01;
  wire qualify = intHit & ((rxLen == LEN_CONT) ? cwChanged :
    ((cntNext == target) & (cwChanged | ~atTarget))); // [RL5]

  // Bit capture, first bit ends at the low end; cleared while
  // off so stale bits cannot complete a pattern after enable
  always_ff @(posedge clk_sys)
  begin
    if (!nrst | ~rxEn)
    begin
      rxShift <= 16'h0000;
      rxChk <= 1'b0;
    end
    else
    begin
      rxChk <= rxStep;
      if (rxStep)
        rxShift <= {linkIn.rxBit, rxShift[15:1]}; // [RL18]
    end
  end

  // Gap counter since the last detected pattern, saturating
  always_ff @(posedge clk_sys)
  begin
    if (!nrst | ~rxEn)
      bitsSince <= 5'h1f;
    else if (patHit)
      bitsSince <= {4'h0, rxStep};
    else if (rxStep & (bitsSince != 5'h1f))
      bitsSince <= bitsSince + 5'h01;
  end

  // Run tracking; an errored pattern never counts
  always_ff @(posedge clk_sys)
  begin
    if (!nrst | ~rxEn)
    begin
      prevCw <= CW_RST;
      runCw <= CW_RST;
      runCnt <= 5'h00;
    end
    else if (patHit)
    begin
      prevCw <= hitCw;
      if (hitCw != runCw)
      begin
        runCw <= hitCw; // [RL7]
        runCnt <= {4'h0, intHit};
      end
      else if (intHit)
        runCnt <= cntNext; // [RL2]
    end
  end

  // Busy bit: pulse for single length, else held to qualify
  always_ff @(posedge clk_sys)
  begin
    if (!nrst | ~rxEn)
      rxActive <= 1'b0;
    else if (rxLen == LEN_ONE)
      rxActive <= patHit; // [RL23]
    else if (qualify)
      rxActive <= 1'b0; // [RL23]
    else if (patHit)
      rxActive <= 1'b1; // [RL22]
  end

  // Received codeword and flags; hardware set beats read clear.
  // Qualify can only fire while enabled, so a disabled
  // receiver leaves these untouched.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rxCw <= CW_RST;
      rxNew <= 1'b0;
      rxLost <= 1'b0;
    end
    else
    begin
      if (qualify)
        rxCw <= hitCw; // [RL6] [RL26]
      rxNew <= qualify | (rxNew & ~rdRx); // [RL19]
      rxLost <= (qualify & rxNew) | (rxLost & ~rdRx); // [RL20]
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  logic pend;
  logic [5:0] curCw;
  logic [3:0] bitIdx;
  logic [4:0] repLeft;
  logic txBit;
  logic txEvt;
  cwt_tx_state_t next_txState;

  // Writes land only while the sender is enabled
  wire txWrite = wrFire & selTx & txOn; // [RL12]

  // Under link1 priority a codeword may start only when the link1 buffer and output are quiet
  wire canGo = ~l1Pri | (linkIn.l1Empty & linkIn.l1Idle); // [RL15]
  wire l1Wants = l1Pri & ~linkIn.l1Empty; // [RL15] [RL16]
  wire startNow = pend & canGo & txOn;

  // Pattern as sent, bit 0 leaves first
  wire [15:0] patWord = {1'b0, curCw, 1'b0, FLAG_ONES}; // [RL24] [RL17]
  wire lastBit = linkIn.bitEn & (bitIdx == PAT_LAST);

  // Repeat count loaded at message start; continuous loads
  // one so a length change stops it at the next boundary
  wire [4:0] repLoad =
    (txLen == LEN_TEN) ? CNT_TEN :
    (txLen == LEN_25) ? CNT_25 : CNT_ONE; // [RL8]
  wire msgEnd = (txLen != LEN_CONT) & (repLeft <= CNT_ONE);

  // Next state of the sender
  always_comb
  begin
    next_txState = txState;
    case (txState)
      TX_IDLE:
        if (startNow)
          next_txState = TX_SEND;
      TX_SEND:
        if (~txOn)
          next_txState = TX_IDLE;
        else if (lastBit & msgEnd)
          next_txState = startNow ? TX_SEND : TX_IDLE; // [RL10]
        else if (lastBit & l1Wants)
          next_txState = TX_HOLD; // [RL16] [RL15]
      TX_HOLD:
        if (~txOn)
          next_txState = TX_IDLE;
        else if (canGo)
          next_txState = TX_SEND; // [RL15]
      default:
        next_txState = TX_IDLE;
    endcase
  end

  // A start is leaving idle, or chaining at message end
  wire txStart = startNow & ((txState == TX_IDLE)
    | ((txState == TX_SEND) & lastBit & msgEnd & txOn));

  // State, pattern position and repeat count
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      txState <= TX_IDLE;
      bitIdx <= 4'h0;
      repLeft <= 5'h00;
      curCw <= CW_RST;
    end
    else
    begin
      txState <= next_txState;
      if (txStart)
      begin
        curCw <= txCwReg;
        repLeft <= repLoad; // [RL8]
        bitIdx <= 4'h0;
      end
      else if ((txState == TX_SEND) & linkIn.bitEn)
      begin
        bitIdx <= bitIdx + 4'h1;
        if (lastBit & ~msgEnd & (txLen != LEN_CONT))
          repLeft <= repLeft - 5'h01;
      end
      else if (txState != TX_SEND)
        bitIdx <= 4'h0;
    end
  end

  // Codeword register and the pending-message flag
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      txCwReg <= CW_RST;
      pend <= 1'b0;
    end
    else
    begin
      if (txWrite)
        txCwReg <= pwdata[5:0];
      if (~txOn)
        pend <= 1'b0; // [RL12]
      else
        pend <= txWrite | (pend & ~txStart); // [RL9]
    end
  end

  // Line bit and start event; idle line sends ones
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      txBit <= 1'b1;
      txEvt <= 1'b0;
    end
    else
    begin
      txEvt <= txStart; // [RL9]
      if (linkIn.bitEn)
        txBit <= (txState == TX_SEND) ? patWord[bitIdx] : 1'b1; // [RL17]
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Suspend link1 at once on a write under codeword priority,
  // well inside the ABORT_BITS limit; link1 keeps taking
  // buffer writes because nothing here gates its buffer
  assign linkOut.l1Suspend = (txState == TX_SEND)
    | ((mode == MODE_CWPRI) & pend); // [RL13] [RL14]
  assign linkOut.cwOwns = (txState == TX_SEND); // [RL10]
  assign linkOut.txBit = txBit;
  assign evt.rxCwEvt = qualify; // [RL6]
  assign evt.txCwEvt = txEvt; // [RL9]

endmodule

// file: verif/cwt_monitor.sv
// Port checker for the codeword transceiver
`timescale 1ns/1ps
module cwt_monitor
  import cwt_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and events
  input cwt_pkg::cwt_link_in_t linkIn,
  input cwt_pkg::cwt_link_out_t linkOut,
  input cwt_pkg::cwt_evt_t evt
);
  logic [7:0] cfg;
  logic wrDone;
  logic wrTx;
  logic txOn;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Completed writes; config is shadowed since mode is not on a port
  assign wrDone = psel && penable && pready && pwrite && !pslverr;
  assign wrTx = wrDone && paddr[9:2] == IDX_TXCW;
  assign txOn = cfg[CFG_MODE_LSB+1];
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      cfg <= CFG_RST;
    else if (wrDone && paddr[9:2] == IDX_CFG)
      cfg <= pwdata[7:0];
  end

  // ------
  // Multi-step behaviour
  // ------
  sequence sAccess;
    !pready ##1 pready;
  endsequence
  sequence sRxEvt;
    $past(linkIn.bitEn) && evt.rxCwEvt ##1 !evt.rxCwEvt;
  endsequence

  apb_wait_a: assert property ($rose(penable) && psel |-> sAccess)
    else $error("access phase not answered after one wait state");
  rx_evt_a: assert property (evt.rxCwEvt |-> sRxEvt)
    else $error("receive event not a pulse after a slot");
  rx_off_a: assert property (!cfg[CFG_RXEN_BIT] &&
    !$past(cfg[CFG_RXEN_BIT]) |-> !evt.rxCwEvt)
    else $error("receive event while receiver off");
  tx_start_a: assert property ($rose(linkOut.cwOwns) |-> evt.txCwEvt)
    else $error("message start without transmit event");
  tx_write_a: assert property (wrTx && cfg[1:0] == MODE_CWPRI &&
    !linkOut.cwOwns |-> ##2 linkOut.cwOwns)
    else $error("codeword write did not start a message");
  tx_off_a: assert property (!txOn && !$past(txOn) |-> !linkOut.cwOwns)
    else $error("sending while transmitter disabled");
  own_suspend_a: assert property (linkOut.cwOwns |-> linkOut.l1Suspend)
    else $error("link1 not suspended while codeword owns channel");
  // A codeword write under codeword priority stops link1 quickly
  l1_abort_a: assert property (wrTx && cfg[1:0] == MODE_CWPRI |->
    ##[1:8] linkOut.l1Suspend)
    else $error("link1 not suspended after codeword write");
  l1_first_a: assert property ($rose(linkOut.cwOwns) &&
    cfg[1:0] == MODE_L1PRI |-> $past(linkIn.l1Empty && linkIn.l1Idle))
    else $error("codeword started while link1 busy");
  txbit_hold_a: assert property (!$past(linkIn.bitEn) |->
    $stable(linkOut.txBit))
    else $error("sent bit changed outside a slot");
  idle_mark_a: assert property ($past(linkIn.bitEn) &&
    !$past(linkOut.cwOwns) |-> linkOut.txBit)
    else $error("channel not idle ones after message");
endmodule

bind cwt_transceiver cwt_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk_sys, .nrst,
  .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .linkIn, .linkOut, .evt);

// file: verif/cwt_link_model.sv
// Far-end link model: bit slots, received patterns, sent-bit capture
`timescale 1ns/1ps
module cwt_link_model
  import cwt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link1 traffic pending at the framer
  input wire logic l1Busy,
  // Link toward the transceiver
  output cwt_pkg::cwt_link_in_t linkIn,
  input cwt_pkg::cwt_link_out_t linkOut
);
  logic [1:0] slotCnt;
  logic idleBit;
  logic patBit = 1'b0;
  logic sending = 1'b0;
  logic [15:0] txSeen;
  int ownBits;

  // Slot every fourth cycle; idle line toggles so no stale value shows
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      slotCnt <= 2'h0;
      idleBit <= 1'b0;
      txSeen <= 16'h0000;
      ownBits <= 0;
    end
    else
    begin
      slotCnt <= slotCnt + 2'h1;
      if (linkIn.bitEn)
      begin
        idleBit <= ~idleBit;
        txSeen <= {linkOut.txBit, txSeen[15:1]};
        if (linkOut.cwOwns)
          ownBits <= ownBits + 1;
      end
    end
  end
  assign linkIn = {slotCnt == 2'h3, sending ? patBit : idleBit, !l1Busy,
    !l1Busy};

  // Back-to-back patterns: ones, zero, codeword from bit 0, zero
  task automatic sendPat(input logic [5:0] cw, input int n);
    logic [15:0] pat;
    pat = {1'b0, cw, 1'b0, FLAG_ONES};
    repeat (n)
      for (int i = 0; i < 16; i++)
      begin
        @(posedge clk_sys iff linkIn.bitEn);
        patBit <= pat[i];
        sending <= 1'b1;
      end
    @(posedge clk_sys iff linkIn.bitEn);
    sending <= 1'b0;
  endtask
endmodule

// file: verif/tb_top.sv
// Testbench for the codeword transceiver
`timescale 1ns/1ps
module tb_top;
  import cwt_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic l1Busy = 1'b0;
  cwt_link_in_t linkIn;
  cwt_link_out_t linkOut;
  cwt_evt_t evt;
  int nMismatch = 0;
  int checksDone = 0;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  cwt_transceiver #(.ADDR_W(12)) i_dut (.clk_sys, .nrst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .linkIn,
    .linkOut, .evt);
  cwt_link_model i_link (.clk_sys, .nrst, .l1Busy, .linkIn, .linkOut);

  // ------
  // Checking and closing
  // ------
  task automatic check(input string nm, input logic [32:0] got, exp);
    checksDone++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------
  // Bus and link tasks
  // ------
  // One APB transfer; waits for the slave, never a fixed count
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] wd, output logic [32:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= w;
    pwdata <= {24'h00_0000, wd};
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      nMismatch++;
      completeRun();
    end
    rd = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [32:0] rd;
    apb(1'b1, idx, d, rd);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    logic [32:0] rd;
    apb(1'b0, idx, 8'h00, rd);
    check($sformatf("reg %h", idx), rd, {25'h000_0000, exp});
  endtask

  // Bounded wait on channel ownership
  task automatic waitOwns(input logic v);
    int n;
    n = 0;
    while (linkOut.cwOwns !== v && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000)
    begin
      nMismatch++;
      completeRun();
    end
  endtask

  // One message with codeword priority; continuous is stopped by length
  task automatic txMsg(input logic [1:0] len);
    logic [5:0] cw;
    int b0;
    int n;
    cw = 6'h15 ^ {4'h0, len};
    n = (len == LEN_ONE) ? 1 : (len == LEN_TEN) ? 10 : 25;
    b0 = i_link.ownBits;
    wr(IDX_CFG, {4'h0, len, MODE_CWPRI});
    wr(IDX_TXCW, {2'b00, cw});
    waitOwns(1'b1);
    rdChk(IDX_STAT, 8'h80);
    rdChk(IDX_TXCW, {2'b00, cw});
    if (len == LEN_CONT)
    begin
      repeat (100) @(posedge clk_sys);
      wr(IDX_CFG, {4'h0, LEN_ONE, MODE_CWPRI});
      n = (i_link.ownBits - b0 + 31) / 16;
    end
    waitOwns(1'b0);
    repeat (5) @(posedge clk_sys);
    if (len != LEN_CONT)
      check("bits", 33'(i_link.ownBits - b0), 33'(16 * n));
    check("bits mod", 33'((i_link.ownBits - b0) % 16), 33'(0));
    check("pattern", 33'(i_link.txSeen), {18'h0, cw, 1'b0, FLAG_ONES});
    rdChk(IDX_STAT, 8'h00);
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    logic [32:0] rd;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rdChk(IDX_CFG, CFG_RST);
    rdChk(IDX_TXCW, {2'b00, CW_RST});
    rdChk(IDX_RXCW, 8'h00);
    rdChk(IDX_STAT, 8'h00);
    apb(1'b0, 8'h10, 8'h00, rd);
    check("unmapped", rd, {1'b1, 32'h0000_0000});
    $display("test reset done");
    wr(IDX_CFG, 8'h80);
    i_link.sendPat(6'h2d, 1);
    rdChk(IDX_RXCW, 8'h6d);
    rdChk(IDX_RXCW, 8'h2d);
    i_link.sendPat(6'h2c, 1);
    i_link.sendPat(6'h13, 2);
    rdChk(IDX_RXCW, 8'hd3);
    rdChk(IDX_RXCW, 8'h13);
    wr(IDX_CFG, 8'hd0);
    i_link.sendPat(6'h0a, 10);
    rdChk(IDX_RXCW, 8'h13);
    i_link.sendPat(6'h21, 11);
    rdChk(IDX_RXCW, 8'h61);
    wr(IDX_CFG, 8'h90);
    i_link.sendPat(6'h0c, 5);
    rdChk(IDX_STAT, 8'h40);
    repeat (40) @(posedge clk_sys);
    i_link.sendPat(6'h0c, 5);
    rdChk(IDX_RXCW, 8'h4c);
    rdChk(IDX_STAT, 8'h00);
    wr(IDX_CFG, 8'h00);
    i_link.sendPat(6'h3f, 1);
    rdChk(IDX_RXCW, 8'h0c);
    $display("test receive done");
    for (int l = 0; l < 4; l++)
      txMsg(2'(l));
    wr(IDX_CFG, 8'h00);
    wr(IDX_TXCW, 8'h2a);
    rdChk(IDX_TXCW, 8'h16);
    check("owns off", {32'h0, linkOut.cwOwns}, 33'h0_0000_0000);
    $display("test transmit done");
    l1Busy <= 1'b1;
    wr(IDX_CFG, 8'h0f);
    wr(IDX_TXCW, 8'h0c);
    repeat (40) @(posedge clk_sys);
    check("owns held", {32'h0, linkOut.cwOwns}, 33'h0_0000_0000);
    l1Busy <= 1'b0;
    waitOwns(1'b1);
    repeat (100) @(posedge clk_sys);
    l1Busy <= 1'b1;
    waitOwns(1'b0);
    check("boundary", 33'(i_link.ownBits % 16), 33'(0));
    rdChk(IDX_STAT, 8'h80);
    wr(IDX_CFG, 8'h00);
    rdChk(IDX_STAT, 8'h00);
    $display("test priority done");
    completeRun();
  end
endmodule
